// *** design/srg_core.sv ***
// Setpoint rate limit, single ramp and ramp/soak profile generator
//
// How it works
// (R1) Rate limit moves setpoint gradually toward target
// (R2) Separate up and down rates, units/hour
// (R3) Zero rate means immediate jump
// (R4) Power return during rate: reload measured value
// (R5) Single ramp to final over 1-255 minutes
// (R6) Single ramp only without rate or profile
// (R7) Run/hold command toggles run and freeze
// (R8) Remaining ramp minutes kept and readable
// (R9) Reaching final setpoint switches run to hold
// (R10) Power return mid-ramp: hold at start value
// (R11) Power return seeds setpoint from measured value
// (R12) Twelve alternating ramp/soak segments, first to last
// (R13) Profile only while single ramp disabled
// (R14) Working and target setpoints separately readable
// (R15) First segment 1-11, last even 2-12
// (R16) Profile repeats 0 to 99 times
// (R17) Steps driven by one-second time base
`timescale 1ns/1ps
module srg_core #(
	parameter int unsigned TICK_CYCLES = srg_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register port
	input wire logic [5:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Process side
	input wire logic [15:0] measured_process_value,
	input wire logic power_restored,
	// Setpoint outputs
	output logic [15:0] working_setpoint,
	output logic [15:0] target_setpoint,
	output logic ramp_running,
	output logic [7:0] ramp_minutes_left
);
	typedef struct packed {
		logic [2:0] ctrl;
		logic [15:0] up_rate;
		logic [15:0] dn_rate;
		logic [15:0] local_sp;
		logic [15:0] final_sp;
		logic [7:0] ramp_min;
		logic [3:0] first_seg;
		logic [3:0] last_seg;
		logic [6:0] recycles;
		logic [11:0][15:0] seg_sp;
		logic [11:0][15:0] seg_par;
		logic [15:0] working;
		logic [15:0] goal;
		logic [15:0] ramp_start_sp;
		logic [15:0] ramp_delta;
		logic [31:0] err;
		srg_pkg::srg_run_type run;
		logic ramp_active;
		logic [5:0] sec_cnt;
		logic [15:0] min_left;
		logic [3:0] seg_idx;
		logic [6:0] recyc_left;
		logic pwr_s1;
		logic pwr_s2;
		logic pwr_s3;
		logic [15:0] rdata;
	} srg_state_type;

	localparam srg_state_type STATE_RST = '{
		ctrl: srg_pkg::RST_CTRL,
		ramp_min: srg_pkg::RST_RAMP_MIN,
		first_seg: srg_pkg::RST_FIRST,
		last_seg: srg_pkg::RST_LAST,
		recycles: srg_pkg::RST_RECYC,
		run: srg_pkg::SRG_HOLD,
		default: '0
	};

	srg_state_type r;
	srg_state_type n;
	logic tick;
	logic pwr_evt;
	logic moving;
	logic adv;
	logic cmd;
	srg_pkg::srg_mode_type mode_c;
	logic [15:0] goal_c;
	logic [15:0] rate_c;
	logic [31:0] div_c;
	logic [31:0] err_sum;
	logic [3:0] seg_sel;
	logic [3:0] nxt_idx;
	logic [3:0] nxt_sel;
	logic [3:0] f_first;
	logic [3:0] f_last;
	logic [6:0] f_recyc;

	// Update time base
	srg_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.tick(tick) // [R17]
	);

	// Next-state logic
	always_comb begin
		n = r;
		n.pwr_s1 = power_restored;
		n.pwr_s2 = r.pwr_s1;
		n.pwr_s3 = r.pwr_s2;
		pwr_evt = r.pwr_s2 & ~r.pwr_s3;
		adv = 1'b0;
		cmd = 1'b0;
		nxt_idx = 4'h0;
		nxt_sel = 4'h0;
		f_first = wdata[srg_pkg::PROF_FIRST_LSB +: 4];
		f_last = wdata[srg_pkg::PROF_LAST_LSB +: 4];
		f_recyc = wdata[srg_pkg::PROF_RECYC_LSB +: 7];
		seg_sel = (r.seg_idx == 4'h0) ? 4'h0 : 4'(r.seg_idx - 4'h1);

		// Mode arbitration
		if (r.ctrl[srg_pkg::CTRL_RAMP_BIT] && !r.ctrl[srg_pkg::CTRL_RATE_BIT]
				&& !r.ctrl[srg_pkg::CTRL_PROF_BIT]) begin
			mode_c = srg_pkg::MODE_RAMP; // [R6]
		end else if (r.ctrl[srg_pkg::CTRL_PROF_BIT] && !r.ctrl[srg_pkg::CTRL_RAMP_BIT]) begin
			mode_c = srg_pkg::MODE_PROF; // [R13]
		end else if (r.ctrl[srg_pkg::CTRL_RATE_BIT]) begin
			mode_c = srg_pkg::MODE_RATE;
		end else begin
			mode_c = srg_pkg::MODE_DIRECT;
		end

		// Goal, rate and divisor for the stepping engine
		case (mode_c)
			srg_pkg::MODE_RATE: begin
				goal_c = r.local_sp;
				rate_c = (r.local_sp >= r.working) ? r.up_rate : r.dn_rate; // [R2]
				div_c = srg_pkg::SEC_PER_HOUR;
			end
			srg_pkg::MODE_RAMP: begin
				goal_c = r.final_sp;
				rate_c = r.ramp_delta;
				div_c = {18'h0, 14'({6'h0, r.ramp_min} * srg_pkg::SEC_PER_MIN)}; // [R5]
			end
			srg_pkg::MODE_PROF: begin
				goal_c = r.seg_sp[seg_sel];
				rate_c = r.seg_par[seg_sel];
				div_c = srg_pkg::SEC_PER_HOUR;
			end
			default: begin
				goal_c = r.local_sp;
				rate_c = 16'h0;
				div_c = srg_pkg::SEC_PER_HOUR;
			end
		endcase
		n.goal = goal_c; // [R14]

		// Register writes
		if (wr) begin
			case (addr)
				srg_pkg::OFS_CTRL: n.ctrl = wdata[2:0];
				srg_pkg::OFS_UP_RATE: n.up_rate = wdata;
				srg_pkg::OFS_DN_RATE: n.dn_rate = wdata;
				srg_pkg::OFS_FINAL_SP: n.final_sp = wdata;
				srg_pkg::OFS_LOCAL_SP: begin
					n.local_sp = wdata;
					if (mode_c == srg_pkg::MODE_RAMP && !r.ramp_active) begin
						n.working = wdata;
					end
				end
				srg_pkg::OFS_RAMP_MIN: begin
					if (wdata[7:0] != 8'h0) begin
						n.ramp_min = wdata[7:0]; // [R5]
					end
				end
				srg_pkg::OFS_PROF_CFG: begin
					// Whole write refused when any field is out of range
					if (f_first != 4'h0 && f_first <= srg_pkg::FIRST_MAX
							&& f_last >= srg_pkg::LAST_MIN && f_last <= srg_pkg::LAST_MAX
							&& !f_last[0] && f_recyc <= srg_pkg::RECYC_MAX) begin
						n.first_seg = f_first; // [R15]
						n.last_seg = f_last; // [R15]
						n.recycles = f_recyc; // [R16]
					end
				end
				srg_pkg::OFS_CMD: cmd = wdata[srg_pkg::CMD_RUNHOLD_BIT];
				default: begin
					if (addr[3:0] < srg_pkg::NUM_SEG) begin
						if (addr[5:4] == srg_pkg::SEG_SP_PAGE) begin
							n.seg_sp[addr[3:0]] = wdata; // [R12]
						end else if (addr[5:4] == srg_pkg::SEG_PAR_PAGE) begin
							n.seg_par[addr[3:0]] = wdata; // [R12]
						end
					end
				end
			endcase
		end

		// Run/hold toggle, starting a ramp or profile from hold
		if (cmd && (mode_c == srg_pkg::MODE_RAMP || mode_c == srg_pkg::MODE_PROF)) begin
			if (r.run == srg_pkg::SRG_RUN) begin
				n.run = srg_pkg::SRG_HOLD; // [R7]
			end else begin
				n.run = srg_pkg::SRG_RUN; // [R7]
				if (mode_c == srg_pkg::MODE_RAMP && !r.ramp_active) begin
					n.ramp_active = 1'b1;
					n.ramp_start_sp = r.working;
					n.ramp_delta = (r.final_sp >= r.working) ? 16'(r.final_sp - r.working)
						: 16'(r.working - r.final_sp);
					n.min_left = {8'h0, r.ramp_min}; // [R8]
					n.sec_cnt = 6'h0;
					n.err = 32'h0;
				end else if (mode_c == srg_pkg::MODE_PROF && r.seg_idx == 4'h0) begin
					n.seg_idx = r.first_seg; // [R12]
					n.recyc_left = r.recycles; // [R16]
					n.min_left = r.seg_par[4'(r.first_seg - 4'h1)];
					n.sec_cnt = 6'h0;
					n.err = 32'h0;
				end
			end
		end

		// Stepping engine: error accumulates rate each second, one unit per divisor
		moving = (mode_c == srg_pkg::MODE_RATE)
			|| (r.run == srg_pkg::SRG_RUN
			&& ((mode_c == srg_pkg::MODE_RAMP && r.ramp_active)
			|| (mode_c == srg_pkg::MODE_PROF && r.seg_idx[0])));
		err_sum = r.err + (tick ? {16'h0, rate_c} : 32'h0); // [R17]
		if (moving) begin
			if (r.working == goal_c) begin
				n.err = 32'h0;
			end else if (rate_c == 16'h0) begin
				n.working = goal_c; // [R3]
				n.err = 32'h0;
			end else if (err_sum >= div_c) begin
				n.working = (goal_c > r.working) ? 16'(r.working + 16'h1)
					: 16'(r.working - 16'h1); // [R1]
				n.err = err_sum - div_c;
			end else begin
				n.err = err_sum;
			end
		end

		// Single ramp minute count and completion
		if (mode_c == srg_pkg::MODE_RAMP && r.run == srg_pkg::SRG_RUN && r.ramp_active) begin
			if (tick) begin
				if (r.sec_cnt == srg_pkg::SEC_LAST) begin
					n.sec_cnt = 6'h0;
					if (r.min_left != 16'h0) begin
						n.min_left = 16'(r.min_left - 16'h1); // [R8]
					end
				end else begin
					n.sec_cnt = 6'(r.sec_cnt + 6'h1);
				end
			end
			if (r.min_left == 16'h0) begin
				n.working = r.final_sp;
			end
			if (r.working == r.final_sp) begin
				n.run = srg_pkg::SRG_HOLD; // [R9]
				n.ramp_active = 1'b0; // [R9]
			end
		end

		// Profile sequencing: odd segments ramp, even segments soak
		if (mode_c == srg_pkg::MODE_PROF && r.run == srg_pkg::SRG_RUN && r.seg_idx != 4'h0) begin
			if (r.seg_idx[0]) begin
				adv = (r.working == goal_c);
			end else begin
				if (tick) begin
					if (r.sec_cnt == srg_pkg::SEC_LAST) begin
						n.sec_cnt = 6'h0;
						if (r.min_left != 16'h0) begin
							n.min_left = 16'(r.min_left - 16'h1);
						end
					end else begin
						n.sec_cnt = 6'(r.sec_cnt + 6'h1);
					end
				end
				adv = (r.min_left == 16'h0);
			end
			if (adv) begin
				if (r.seg_idx >= r.last_seg || r.seg_idx >= srg_pkg::NUM_SEG) begin
					if (r.recyc_left != 7'h0) begin
						n.recyc_left = 7'(r.recyc_left - 7'h1); // [R16]
						nxt_idx = r.first_seg;
					end else begin
						n.run = srg_pkg::SRG_HOLD; // Controls at the last setpoint
					end
				end else begin
					nxt_idx = 4'(r.seg_idx + 4'h1); // [R12]
				end
				// Parameter slot of the segment being entered, worked out before it is read
				nxt_sel = (nxt_idx == 4'h0) ? 4'h0 : 4'(nxt_idx - 4'h1);
				n.seg_idx = nxt_idx;
				n.err = 32'h0;
				n.sec_cnt = 6'h0;
				n.min_left = r.seg_par[nxt_sel];
			end
		end

		// No ramping: working setpoint follows local setpoint
		if (mode_c == srg_pkg::MODE_DIRECT) begin
			n.working = n.local_sp;
		end

		// Restart after power returns
		if (pwr_evt) begin
			n.err = 32'h0;
			if (mode_c == srg_pkg::MODE_RAMP && r.ramp_active) begin
				n.working = r.ramp_start_sp; // [R10]
				n.run = srg_pkg::SRG_HOLD; // [R10]
				n.ramp_active = 1'b0;
				n.sec_cnt = 6'h0;
			end else begin
				n.working = measured_process_value; // [R4] [R11]
			end
		end

		// Read data, valid in the cycle after the strobe
		n.rdata = 16'h0;
		if (rd) begin
			case (addr)
				srg_pkg::OFS_CTRL: n.rdata = {13'h0, r.ctrl};
				srg_pkg::OFS_UP_RATE: n.rdata = r.up_rate;
				srg_pkg::OFS_DN_RATE: n.rdata = r.dn_rate;
				srg_pkg::OFS_LOCAL_SP: n.rdata = r.local_sp;
				srg_pkg::OFS_FINAL_SP: n.rdata = r.final_sp;
				srg_pkg::OFS_RAMP_MIN: n.rdata = {8'h0, r.ramp_min};
				srg_pkg::OFS_PROF_CFG: n.rdata = {1'b0, r.recycles, r.last_seg, r.first_seg};
				srg_pkg::OFS_STATUS: n.rdata = {12'h0, r.ramp_active, mode_c,
					r.run == srg_pkg::SRG_RUN};
				srg_pkg::OFS_WORKING: n.rdata = r.working; // [R14]
				srg_pkg::OFS_TARGET: n.rdata = r.goal; // [R14]
				srg_pkg::OFS_MIN_LEFT: n.rdata = r.min_left; // [R8]
				srg_pkg::OFS_SEG_POS: n.rdata = {1'b0, r.recyc_left, 4'h0, r.seg_idx};
				default: begin
					if (addr[3:0] < srg_pkg::NUM_SEG) begin
						if (addr[5:4] == srg_pkg::SEG_SP_PAGE) begin
							n.rdata = r.seg_sp[addr[3:0]];
						end else if (addr[5:4] == srg_pkg::SEG_PAR_PAGE) begin
							n.rdata = r.seg_par[addr[3:0]];
						end
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			r <= STATE_RST;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign rdata = r.rdata;
	assign working_setpoint = r.working;
	assign target_setpoint = r.goal;
	assign ramp_running = r.run[0];
	assign ramp_minutes_left = r.min_left[7:0];

	// Rate limit moves one unit at most per cycle
	rate_one_step_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
		(mode_c == srg_pkg::MODE_RATE && r.up_rate != 16'h0 && r.dn_rate != 16'h0
		&& !pwr_evt && !wr) |=> (r.working == $past(r.working)
		|| r.working == 16'($past(r.working) + 16'h1)
		|| r.working == 16'($past(r.working) - 16'h1)))
		else $error("Rate limited setpoint moved more than one unit");

	// Zero rate jumps straight to target
	rate_zero_jump_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
		(mode_c == srg_pkg::MODE_RATE && r.up_rate == 16'h0 && goal_c > r.working
		&& !pwr_evt) |=> r.working == $past(goal_c))
		else $error("Zero up rate did not jump to target");

	// Hold freezes the working setpoint
	hold_freeze_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
		(r.run == srg_pkg::SRG_HOLD && (mode_c == srg_pkg::MODE_RAMP
		|| mode_c == srg_pkg::MODE_PROF) && !pwr_evt && !wr) |=> $stable(r.working))
		else $error("Working setpoint moved while on hold");

	// Remaining minutes count down
	ramp_minutes_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
		(mode_c == srg_pkg::MODE_RAMP && r.run == srg_pkg::SRG_RUN && r.ramp_active && tick
		&& r.sec_cnt == srg_pkg::SEC_LAST && r.min_left != 16'h0 && !pwr_evt && !wr)
		|=> r.min_left == 16'($past(r.min_left) - 16'h1))
		else $error("Remaining ramp minutes not decremented");

	// Ramp end returns to hold
	ramp_end_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
		(mode_c == srg_pkg::MODE_RAMP && r.run == srg_pkg::SRG_RUN && r.ramp_active
		&& r.working == r.final_sp) |=> (r.run == srg_pkg::SRG_HOLD && !r.ramp_active))
		else $error("Ramp did not stop at final setpoint");

	// Power return mid-ramp restores start value
	pwr_ramp_restore_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
		(pwr_evt && mode_c == srg_pkg::MODE_RAMP && r.ramp_active)
		|=> (r.run == srg_pkg::SRG_HOLD && r.working == $past(r.ramp_start_sp)))
		else $error("Ramp not restored to start on power return");

	// Power return during rate seeds from measured value
	pwr_rate_seed_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
		(pwr_evt && mode_c == srg_pkg::MODE_RATE) |=> r.working == $past(measured_process_value))
		else $error("Rate restart not seeded from measured value");

	// Mode exclusions
	mode_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R6] [R13]
		(r.ctrl[srg_pkg::CTRL_RATE_BIT] |-> mode_c != srg_pkg::MODE_RAMP)
		and (r.ctrl[srg_pkg::CTRL_RAMP_BIT] |-> mode_c != srg_pkg::MODE_PROF))
		else $error("Mode exclusion violated");

	// Profile bounds
	seg_bounds_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R15] [R16]
		r.first_seg >= 4'h1 && r.first_seg <= srg_pkg::FIRST_MAX && !r.last_seg[0]
		&& r.last_seg >= srg_pkg::LAST_MIN && r.last_seg <= srg_pkg::LAST_MAX
		&& r.recycles <= srg_pkg::RECYC_MAX && r.seg_idx <= srg_pkg::NUM_SEG)
		else $error("Profile configuration out of range");
endmodule // srg_core

// *** common/srg_pkg.sv ***
// Constants and types shared by the setpoint ramp generator
package srg_pkg;
	// Time base
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
	localparam logic [31:0] SEC_PER_HOUR = 32'h0000_0e10;
	localparam logic [13:0] SEC_PER_MIN = 14'h003c;
	localparam logic [5:0] SEC_LAST = 6'h3b;

	// Register word offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_UP_RATE = 6'h01;
	localparam logic [5:0] OFS_DN_RATE = 6'h02;
	localparam logic [5:0] OFS_LOCAL_SP = 6'h03;
	localparam logic [5:0] OFS_FINAL_SP = 6'h04;
	localparam logic [5:0] OFS_RAMP_MIN = 6'h05;
	localparam logic [5:0] OFS_PROF_CFG = 6'h06;
	localparam logic [5:0] OFS_CMD = 6'h07;
	localparam logic [5:0] OFS_STATUS = 6'h08;
	localparam logic [5:0] OFS_WORKING = 6'h09;
	localparam logic [5:0] OFS_TARGET = 6'h0a;
	localparam logic [5:0] OFS_MIN_LEFT = 6'h0b;
	localparam logic [5:0] OFS_SEG_POS = 6'h0c;
	localparam logic [1:0] SEG_SP_PAGE = 2'h2;
	localparam logic [1:0] SEG_PAR_PAGE = 2'h3;

	// Field positions
	localparam int unsigned CTRL_RATE_BIT = 0;
	localparam int unsigned CTRL_RAMP_BIT = 1;
	localparam int unsigned CTRL_PROF_BIT = 2;
	localparam int unsigned CMD_RUNHOLD_BIT = 0;
	localparam int unsigned PROF_FIRST_LSB = 0;
	localparam int unsigned PROF_LAST_LSB = 4;
	localparam int unsigned PROF_RECYC_LSB = 8;

	// Reset values and limits
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [7:0] RST_RAMP_MIN = 8'h01;
	localparam logic [3:0] RST_FIRST = 4'h1;
	localparam logic [3:0] RST_LAST = 4'h2;
	localparam logic [6:0] RST_RECYC = 7'h00;
	localparam logic [3:0] FIRST_MAX = 4'hb;
	localparam logic [3:0] LAST_MIN = 4'h2;
	localparam logic [3:0] LAST_MAX = 4'hc;
	localparam logic [6:0] RECYC_MAX = 7'h63;
	localparam logic [3:0] NUM_SEG = 4'hc;

	typedef enum logic [1:0] {
		SRG_HOLD = 2'b00,
		SRG_RUN = 2'b01
	} srg_run_type;

	typedef enum logic [1:0] {
		MODE_DIRECT = 2'b00,
		MODE_RATE = 2'b01,
		MODE_RAMP = 2'b11,
		MODE_PROF = 2'b10
	} srg_mode_type;
endpackage

// *** design/srg_tick.sv ***
// One-second update strobe for the setpoint ramp generator
`timescale 1ns/1ps
module srg_tick #(
	parameter int unsigned CYCLES = srg_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Strobe
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} srg_tick_state_type;

	srg_tick_state_type r;
	srg_tick_state_type n;

	// Count one period, then pulse for one cycle
	always_comb begin
		n = r;
		n.tick = 1'b0;
		if (r.cnt >= 32'(CYCLES - 1)) begin
			n.cnt = 32'h0;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 32'h1;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick = r.tick;
endmodule // srg_tick

// *** verif/srg_process_model.sv ***
// Process side stand-in: measured value source and power-return pin
`timescale 1ns/1ps
module srg_process_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Bench control
	input wire logic [15:0] pv_in,
	input wire logic pv_load,
	input wire logic outage,
	// Device side
	output logic [15:0] measured_process_value,
	output logic power_restored
);
	logic [2:0] hold_reg;

	// Sensor value follows the bench; the pin stays up long enough for the sync stage
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			measured_process_value <= 16'h0000;
			hold_reg <= 3'h0;
			power_restored <= 1'b0;
		end else begin
			if (pv_load)
				measured_process_value <= pv_in;
			if (outage)
				hold_reg <= 3'h4;
			else if (hold_reg != 3'h0)
				hold_reg <= hold_reg - 3'h1;
			power_restored <= (hold_reg != 3'h0); // Power returns
		end
	end
endmodule // srg_process_model

// *** verif/srg_core_bench.sv ***
// Self-checking bench for the setpoint ramp generator
`timescale 1ns/1ps
module srg_core_bench;
	localparam int unsigned TICKS = 10;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic [15:0] pv_in = 16'h0000;
	logic pv_load = 1'b0;
	logic outage = 1'b0;
	logic [15:0] measured_process_value;
	logic power_restored;
	logic [15:0] working_setpoint;
	logic [15:0] target_setpoint;
	logic ramp_running;
	logic [7:0] ramp_minutes_left;
	int err_count = 0;
	int n_checks = 0;
	logic [15:0] got;
	logic [15:0] s_val;
	logic [15:0] f_val;
	logic [15:0] bad [5] = '{16'h002c, 16'h0031, 16'h00e1, 16'h0020, 16'h6421};
	int unsigned k;

	// Clock
	always #2.5 ref_clk = ~ref_clk;

	srg_core #(.TICK_CYCLES(TICKS)) srg_core_inst (.ref_clk(ref_clk), .nrst(nrst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.measured_process_value(measured_process_value), .power_restored(power_restored),
		.working_setpoint(working_setpoint), .target_setpoint(target_setpoint),
		.ramp_running(ramp_running), .ramp_minutes_left(ramp_minutes_left));

	srg_process_model srg_process_model_inst (.ref_clk(ref_clk), .nrst(nrst),
		.pv_in(pv_in), .pv_load(pv_load), .outage(outage),
		.measured_process_value(measured_process_value), .power_restored(power_restored));

	// Expected mode from the enable bits
	function automatic logic [1:0] mode_of(input logic [2:0] c);
		if (c[1] && !c[0] && !c[2])
			return srg_pkg::MODE_RAMP;
		if (c[2] && !c[1])
			return srg_pkg::MODE_PROF;
		if (c[0])
			return srg_pkg::MODE_RATE;
		return srg_pkg::MODE_DIRECT;
	endfunction

	// Expected profile configuration word
	function automatic logic [15:0] prof_word(input logic [3:0] f, input logic [3:0] l,
		input logic [6:0] r);
		return {1'b0, r, l, f};
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	// Read data are taken in the cycle after the strobe
	task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		got = rdata;
		chk(got, e);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wait_sp(input logic [15:0] e, input int lim);
		for (int i = 0; i < lim && working_setpoint !== e; i++)
			cyc(1);
	endtask

	task automatic wait_run(input logic v, input int lim);
		for (int i = 0; i < lim && ramp_running !== v; i++)
			cyc(1);
	endtask

	task automatic power_cycle(input logic [15:0] v);
		@(posedge ref_clk);
		pv_in <= v;
		pv_load <= 1'b1;
		outage <= 1'b1;
		@(posedge ref_clk);
		pv_load <= 1'b0;
		outage <= 1'b0;
	endtask

	task automatic summarize();
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		summarize();
	end

	// Main sequence
	initial begin
		k = $urandom(67989);
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		rd_chk(srg_pkg::OFS_CTRL, 16'h0000);
		rd_chk(srg_pkg::OFS_RAMP_MIN, 16'h0001);
		rd_chk(srg_pkg::OFS_PROF_CFG, prof_word(4'h1, 4'h2, 7'h00));
		rd_chk(6'h3f, 16'h0000);
		// Every enable combination selects its mode
		for (k = 0; k < 8; k++) begin
			wr_reg(srg_pkg::OFS_CTRL, {13'h0, k[2:0]});
			rd_chk(srg_pkg::OFS_STATUS, {13'h0, mode_of(k[2:0]), 1'b0});
			chk({14'h0, got[2:1]}, {14'h0, mode_of(k[2:0])});
		end
		// Run command ignored when ramp is shadowed by rate or profile
		for (k = 3; k < 7; k += 3) begin
			wr_reg(srg_pkg::OFS_CTRL, k[15:0]);
			wr_reg(srg_pkg::OFS_CMD, 16'h0001);
			cyc(2);
			chk({15'h0, ramp_running}, 16'h0000);
		end
		// Direct mode follows random local setpoints
		wr_reg(srg_pkg::OFS_CTRL, 16'h0000);
		repeat (6) begin
			s_val = 16'($urandom);
			wr_reg(srg_pkg::OFS_LOCAL_SP, s_val);
			cyc(2);
			chk(working_setpoint, s_val);
			chk(target_setpoint, s_val);
		end
		// Rate limit, each direction gradual or immediate
		wr_reg(srg_pkg::OFS_LOCAL_SP, 16'h1000);
		wr_reg(srg_pkg::OFS_CTRL, 16'h0001);
		for (k = 0; k < 2; k++) begin
			wr_reg(srg_pkg::OFS_UP_RATE, (k == 0) ? 16'h8ca0 : 16'h0000);
			wr_reg(srg_pkg::OFS_DN_RATE, (k == 0) ? 16'h0000 : 16'h8ca0);
			f_val = (k == 0) ? 16'h1040 : 16'h0fc0;
			wr_reg(srg_pkg::OFS_LOCAL_SP, f_val);
			cyc(40);
			chk({15'h0, working_setpoint == f_val}, 16'h0000);
			rd_chk(srg_pkg::OFS_TARGET, f_val);
			wait_sp(f_val, 100);
			chk(working_setpoint, f_val);
			wr_reg(srg_pkg::OFS_LOCAL_SP, 16'h1000);
			cyc(3);
			chk(working_setpoint, 16'h1000);
		end
		// Power return mid-rate: reseed from measured value, then resume
		wr_reg(srg_pkg::OFS_UP_RATE, 16'h8ca0);
		s_val = {8'h08, 8'($urandom)};
		power_cycle(s_val);
		wait_sp(s_val, 20);
		chk(working_setpoint, s_val);
		wait_sp(16'h1000, 2500);
		chk(working_setpoint, 16'h1000);
		// Single ramp with hold and completion
		wr_reg(srg_pkg::OFS_CTRL, 16'h0000);
		s_val = {8'h02, 8'($urandom)};
		f_val = s_val + 16'h003c;
		wr_reg(srg_pkg::OFS_LOCAL_SP, s_val);
		wr_reg(srg_pkg::OFS_FINAL_SP, f_val);
		wr_reg(srg_pkg::OFS_CTRL, 16'h0002);
		wr_reg(srg_pkg::OFS_CMD, 16'h0001);
		cyc(2);
		chk({15'h0, ramp_running}, 16'h0001);
		chk({8'h00, ramp_minutes_left}, 16'h0001);
		rd_chk(srg_pkg::OFS_MIN_LEFT, 16'h0001);
		cyc(100);
		chk({15'h0, working_setpoint == f_val}, 16'h0000);
		wr_reg(srg_pkg::OFS_CMD, 16'h0001);
		cyc(2);
		got = working_setpoint;
		cyc(50);
		chk(working_setpoint, got);
		chk({15'h0, ramp_running}, 16'h0000);
		wr_reg(srg_pkg::OFS_CMD, 16'h0001);
		cyc(2);
		wait_run(1'b0, 1000);
		chk(working_setpoint, f_val);
		cyc(20);
		chk({ramp_running, working_setpoint[14:0]}, {1'b0, f_val[14:0]});
		// Power return mid-ramp restores the start value in hold
		wr_reg(srg_pkg::OFS_CTRL, 16'h0000);
		wr_reg(srg_pkg::OFS_LOCAL_SP, 16'h0400);
		wr_reg(srg_pkg::OFS_FINAL_SP, 16'h0500);
		wr_reg(srg_pkg::OFS_CTRL, 16'h0002);
		wr_reg(srg_pkg::OFS_CMD, 16'h0001);
		cyc(60);
		power_cycle(16'h0123);
		cyc(10);
		chk(working_setpoint, 16'h0400);
		chk({15'h0, ramp_running}, 16'h0000);
		// Profile configuration limits
		wr_reg(srg_pkg::OFS_CTRL, 16'h0000);
		wr_reg(srg_pkg::OFS_LOCAL_SP, 16'h0300);
		for (k = 0; k < 5; k++) begin
			wr_reg(srg_pkg::OFS_PROF_CFG, bad[k]);
			rd_chk(srg_pkg::OFS_PROF_CFG, prof_word(4'h1, 4'h2, 7'h00));
		end
		wr_reg(srg_pkg::OFS_PROF_CFG, prof_word(4'hb, 4'hc, 7'h63));
		rd_chk(srg_pkg::OFS_PROF_CFG, prof_word(4'hb, 4'hc, 7'h63));
		// Profile run: one ramp, one zero soak, one recycle
		wr_reg(srg_pkg::OFS_PROF_CFG, prof_word(4'h1, 4'h2, 7'h01));
		wr_reg(6'h20, 16'h0310);
		wr_reg(6'h30, 16'h8ca0);
		wr_reg(6'h31, 16'h0000);
		wr_reg(srg_pkg::OFS_CTRL, 16'h0004);
		wr_reg(srg_pkg::OFS_CMD, 16'h0001);
		cyc(2);
		chk({15'h0, ramp_running}, 16'h0001);
		wait_run(1'b0, 500);
		chk(working_setpoint, 16'h0310);
		rd_chk(srg_pkg::OFS_SEG_POS, 16'h0000);
		summarize();
	end
endmodule // srg_core_bench
